/* hw/twm_ctrl.sv */
// Two-wire master transmitter with an APB register file.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Track master send/receive and slave receive operating modes.
// - Bus stalls while the completion flag stands, except after arbitration is lost.
// - Writing one to the flag clears it.
// - START first; address direction picks master mode.
// - Flag, start, enable written together request START.
// - START is generated only on a free bus.
// - After START, set flag with code 08.
// - After address and acknowledge: 18, 20 or 38; D0 or D8 for a read address.
// - Data write with flag low: ignored, collision set.
// - Flag, stop, enable written together send STOP.
// - Repeated START reports 10, keeps the bus.
// - Read bit high, acknowledge low on data.
// - Data byte acked gives 28, else 30.
// - Arbitration lost: 38, release, retry when free.
// - Stop request bit clears after STOP sent.
// - Start and stop together: STOP then START.
module twm_ctrl #(
	parameter logic [7:0] RATE_DEFAULT = twm_pkg::RATE_RST,
	parameter logic [7:0] MR_ADDR_ACK = 8'hD0,
	parameter logic [7:0] MR_ADDR_NACK = 8'hD8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe_n
);
	logic scl_s;
	logic sda_s;
	logic sda_q_ff;
	logic busy_ff;
	logic flag_ff;
	logic acken_ff;
	logic sta_ff;
	logic sto_ff;
	logic wcol_ff;
	logic en_ff;
	logic ie_ff;
	logic [7:0] data_ff;
	logic [7:0] code_ff;
	logic [1:0] presc_ff;
	logic [7:0] rate_ff;
	logic [31:0] prdata_ff;
	twm_pkg::twm_state_t state_ff;
	twm_pkg::twm_mode_t mode_ff;
	logic [1:0] phase_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic [15:0] tmr_ff;
	logic scl_rel_ff;
	logic sda_rel_ff;
	logic rs_ff;
	logic addr_ff;
	logic dir_rd_ff;
	logic wr;
	logic go;
	logic start_seen;
	logic stop_seen;
	logic timed;
	logic stretch;
	logic adv;
	logic start_ok;
	logic lost;
	logic acked;
	logic set_flag;
	logic sto_done;
	logic [7:0] nxt_code;
	logic [15:0] half_m1;

	function automatic logic f_map(input logic [11:0] a);
		f_map = (a == twm_pkg::OFF_CTRL) || (a == twm_pkg::OFF_DATA) ||
			(a == twm_pkg::OFF_STATUS) || (a == twm_pkg::OFF_RATE) ||
			(a == twm_pkg::OFF_INFO);
	endfunction

	// Half a bit period in pclk cycles, less one: (rate + 1) * 4^prescaler.
	function automatic logic [15:0] f_half_m1(input logic [7:0] r, input logic [1:0] p);
		logic [15:0] n;
		n = ({8'h00, r} + 16'h0001) << {p, 1'b0};
		f_half_m1 = n - 16'h0001;
	endfunction

	twm_sync #(
		.WIDTH(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({scl_in, sda_in}),
		.sync_out({scl_s, sda_s})
	);

	assign wr = psel && penable && pwrite;
	assign go = wr && (paddr == twm_pkg::OFF_CTRL) && pwdata[twm_pkg::B_FLAG] && flag_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !f_map(paddr);
	assign prdata = prdata_ff;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = scl_rel_ff;
	assign sda_oe_n = sda_rel_ff;

	assign start_seen = scl_s && sda_q_ff && !sda_s;
	assign stop_seen = scl_s && !sda_q_ff && sda_s;
	assign half_m1 = f_half_m1(rate_ff, presc_ff);
	assign start_ok = en_ff && sta_ff && !flag_ff && !busy_ff && scl_s && sda_s;

	// Bus ownership follows START and STOP seen on the lines, ours or anyone's.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sda_q_ff <= 1'b1;
			busy_ff <= 1'b0;
		end
		else
		begin
			sda_q_ff <= sda_s;
			if (start_seen)
				busy_ff <= 1'b1;
			else if (stop_seen)
				busy_ff <= 1'b0;
		end
	end

	// A released clock held low by the receiver stretches the low phase; the high phase is timed from the clock seen high.
	always_comb
	begin
		timed = (state_ff == twm_pkg::ST_START) || (state_ff == twm_pkg::ST_SHIFT) ||
			(state_ff == twm_pkg::ST_RSTART) || (state_ff == twm_pkg::ST_STOP);
		stretch = timed && scl_rel_ff && !scl_s;
		adv = timed && !stretch && (tmr_ff >= half_m1);
		acked = !sda_s;
		lost = (state_ff == twm_pkg::ST_SHIFT) && (phase_ff == 2'h1) && adv &&
			(bit_ff != twm_pkg::LAST_BIT) && shift_ff[7] && !sda_s;
		set_flag = 1'b0;
		sto_done = 1'b0;
		nxt_code = code_ff;
		if ((state_ff == twm_pkg::ST_START) && (phase_ff == 2'h1) && adv)
		begin
			set_flag = 1'b1;
			nxt_code = rs_ff ? twm_pkg::CODE_RSTART : twm_pkg::CODE_START;
		end
		else if (lost)
		begin
			set_flag = 1'b1;
			nxt_code = twm_pkg::CODE_LOST;
		end
		else if ((state_ff == twm_pkg::ST_SHIFT) && (phase_ff == 2'h1) && adv &&
			(bit_ff == twm_pkg::LAST_BIT))
		begin
			set_flag = 1'b1;
			if (addr_ff && dir_rd_ff)
				nxt_code = acked ? MR_ADDR_ACK : MR_ADDR_NACK;
			else if (addr_ff)
				nxt_code = acked ? twm_pkg::CODE_AW_ACK : twm_pkg::CODE_AW_NACK;
			else
				nxt_code = acked ? twm_pkg::CODE_D_ACK : twm_pkg::CODE_D_NACK;
		end
		else if ((state_ff == twm_pkg::ST_STOP) && (phase_ff == 2'h2) && adv)
			sto_done = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tmr_ff <= 16'h0000;
		else if (!timed || adv || stretch)
			tmr_ff <= 16'h0000;
		else
			tmr_ff <= tmr_ff + 16'h0001;
	end

	// The hardware set wins over a software clear arriving in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_ff <= 1'b0;
			code_ff <= twm_pkg::CODE_RST;
		end
		else
		begin
			if (set_flag)
				flag_ff <= 1'b1;
			else if (go)
				flag_ff <= 1'b0;
			code_ff <= nxt_code;
		end
	end

	// Control, data, prescaler and rate registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acken_ff <= 1'b0;
			sta_ff <= 1'b0;
			sto_ff <= 1'b0;
			wcol_ff <= 1'b0;
			en_ff <= 1'b0;
			ie_ff <= 1'b0;
			data_ff <= twm_pkg::DATA_RST;
			presc_ff <= twm_pkg::PRESC_RST;
			rate_ff <= RATE_DEFAULT;
		end
		else
		begin
			if (wr && (paddr == twm_pkg::OFF_CTRL))
			begin
				acken_ff <= pwdata[twm_pkg::B_ACKEN];
				sta_ff <= pwdata[twm_pkg::B_STA];
				sto_ff <= pwdata[twm_pkg::B_STO];
				en_ff <= pwdata[twm_pkg::B_EN];
				ie_ff <= pwdata[twm_pkg::B_IE];
			end
			else if (sto_done)
				sto_ff <= 1'b0;
			if (wr && (paddr == twm_pkg::OFF_DATA))
			begin
				if (flag_ff)
				begin
					data_ff <= pwdata[7:0];
					wcol_ff <= 1'b0;
				end
				else
					wcol_ff <= 1'b1;
			end
			if (wr && (paddr == twm_pkg::OFF_STATUS))
				presc_ff <= pwdata[1:0];
			if (wr && (paddr == twm_pkg::OFF_RATE))
				rate_ff <= pwdata[7:0];
		end
	end

	// Read data is captured in the setup phase so it comes from a flip-flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				twm_pkg::OFF_CTRL: prdata_ff <= {24'h00_0000, flag_ff, acken_ff, sta_ff,
					sto_ff, wcol_ff, en_ff, 1'b0, ie_ff};
				twm_pkg::OFF_DATA: prdata_ff <= {24'h00_0000, data_ff};
				// Low bits carry the prescaler, which software masks off.
				twm_pkg::OFF_STATUS: prdata_ff <= {24'h00_0000, code_ff[7:3],
					1'b0, presc_ff};
				twm_pkg::OFF_RATE: prdata_ff <= {24'h00_0000, rate_ff};
				twm_pkg::OFF_INFO: prdata_ff <= {29'h0000_0000, busy_ff, mode_ff};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Mode follows the address direction; losing the bus leaves us an unaddressed slave.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_ff <= twm_pkg::MODE_SRX;
		else if (lost || sto_done || !en_ff)
			mode_ff <= twm_pkg::MODE_SRX;
		else if (set_flag && addr_ff)
			mode_ff <= dir_rd_ff ? twm_pkg::MODE_MRX : twm_pkg::MODE_MTX;
	end

	// Bit engine. Data changes in the step that pulls the clock low and is sampled at the end of the
	// high phase; that step moves both lines, the other protocol steps move only one.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= twm_pkg::ST_IDLE;
			phase_ff <= 2'h0;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			scl_rel_ff <= 1'b1;
			sda_rel_ff <= 1'b1;
			rs_ff <= 1'b0;
			addr_ff <= 1'b0;
			dir_rd_ff <= 1'b0;
		end
		else if (!en_ff)
		begin
			state_ff <= twm_pkg::ST_IDLE;
			phase_ff <= 2'h0;
			scl_rel_ff <= 1'b1;
			sda_rel_ff <= 1'b1;
		end
		else
		begin
			unique case (state_ff)
				twm_pkg::ST_IDLE:
				begin
					if (start_ok)
					begin
						state_ff <= twm_pkg::ST_START;
						phase_ff <= 2'h0;
						rs_ff <= 1'b0;
						sda_rel_ff <= 1'b0;
					end
				end
				twm_pkg::ST_START:
				begin
					if (adv && (phase_ff == 2'h0))
					begin
						scl_rel_ff <= 1'b0;
						phase_ff <= 2'h1;
					end
					else if (adv)
					begin
						state_ff <= twm_pkg::ST_HOLD;
						addr_ff <= 1'b1;
					end
				end
				twm_pkg::ST_HOLD:
				begin
					// The clock stays low here until software clears the flag.
					if (go)
					begin
						phase_ff <= 2'h0;
						if (pwdata[twm_pkg::B_STO])
						begin
							state_ff <= twm_pkg::ST_STOP;
							sda_rel_ff <= 1'b0;
						end
						else if (pwdata[twm_pkg::B_STA])
						begin
							state_ff <= twm_pkg::ST_RSTART;
							sda_rel_ff <= 1'b1;
						end
						else
						begin
							state_ff <= twm_pkg::ST_SHIFT;
							shift_ff <= data_ff;
							bit_ff <= 4'h0;
							sda_rel_ff <= data_ff[7];
							if (addr_ff)
								dir_rd_ff <= data_ff[0];
						end
					end
				end
				twm_pkg::ST_SHIFT:
				begin
					if (adv && (phase_ff == 2'h0))
					begin
						scl_rel_ff <= 1'b1;
						phase_ff <= 2'h1;
					end
					else if (adv && lost)
					begin
						state_ff <= twm_pkg::ST_LOST;
						sda_rel_ff <= 1'b1;
						addr_ff <= 1'b0;
					end
					else if (adv && (bit_ff == twm_pkg::LAST_BIT))
					begin
						// Data stays released while the clock falls, so a not-acknowledged
						// line never drops with the clock and fakes a START.
						state_ff <= twm_pkg::ST_HOLD;
						scl_rel_ff <= 1'b0;
						sda_rel_ff <= 1'b1;
						addr_ff <= 1'b0;
					end
					else if (adv)
					begin
						scl_rel_ff <= 1'b0;
						phase_ff <= 2'h0;
						bit_ff <= bit_ff + 4'h1;
						shift_ff <= {shift_ff[6:0], 1'b1};
						// The ninth slot is released so the receiver can acknowledge.
						sda_rel_ff <= (bit_ff == 4'h7) ? 1'b1 : shift_ff[6];
					end
				end
				twm_pkg::ST_LOST:
				begin
					// A pending start request waits in idle for a free bus.
					if (go)
						state_ff <= twm_pkg::ST_IDLE;
				end
				twm_pkg::ST_RSTART:
				begin
					if (adv && (phase_ff == 2'h0))
					begin
						scl_rel_ff <= 1'b1;
						phase_ff <= 2'h1;
					end
					else if (adv)
					begin
						state_ff <= twm_pkg::ST_START;
						phase_ff <= 2'h0;
						rs_ff <= 1'b1;
						sda_rel_ff <= 1'b0;
					end
				end
				twm_pkg::ST_STOP:
				begin
					if (adv && (phase_ff == 2'h0))
					begin
						scl_rel_ff <= 1'b1;
						phase_ff <= 2'h1;
					end
					else if (adv && (phase_ff == 2'h1))
					begin
						sda_rel_ff <= 1'b1;
						phase_ff <= 2'h2;
					end
					else if (adv)
						state_ff <= twm_pkg::ST_IDLE;
				end
				default:
				begin
					state_ff <= twm_pkg::ST_IDLE;
					scl_rel_ff <= 1'b1;
					sda_rel_ff <= 1'b1;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* hw/twm_sync.sv */
// Two-stage synchroniser for the bus line inputs.
`timescale 1ns/1ps
`default_nettype none
module twm_sync #(
	parameter int WIDTH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// Idle bus lines are pulled high, so both stages start there.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= '1;
			sync_ff <= '1;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

/* inc/twm_pkg.sv */
// Register map, field positions, reset values, status codes and types of the two-wire master.
`default_nettype none
package twm_pkg;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_DATA = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_RATE = 12'h00C;
	localparam logic [11:0] OFF_INFO = 12'h010;

	localparam int B_FLAG = 7;
	localparam int B_ACKEN = 6;
	localparam int B_STA = 5;
	localparam int B_STO = 4;
	localparam int B_WCOL = 3;
	localparam int B_EN = 2;
	localparam int B_IE = 0;

	localparam logic [7:0] DATA_RST = 8'hFF;
	localparam logic [7:0] RATE_RST = 8'h05;
	localparam logic [1:0] PRESC_RST = 2'h0;
	localparam logic [7:0] CODE_RST = 8'hF8;
	localparam logic [7:0] CODE_MASK = 8'hF8;

	localparam logic [7:0] CODE_START = 8'h08;
	localparam logic [7:0] CODE_RSTART = 8'h10;
	localparam logic [7:0] CODE_AW_ACK = 8'h18;
	localparam logic [7:0] CODE_AW_NACK = 8'h20;
	localparam logic [7:0] CODE_D_ACK = 8'h28;
	localparam logic [7:0] CODE_D_NACK = 8'h30;
	localparam logic [7:0] CODE_LOST = 8'h38;

	localparam logic [3:0] LAST_BIT = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_SHIFT = 3'h3,
		ST_HOLD = 3'h2,
		ST_STOP = 3'h6,
		ST_RSTART = 3'h7,
		ST_LOST = 3'h5
	} twm_state_t;

	typedef enum logic [1:0] {
		MODE_MTX = 2'h0,
		MODE_MRX = 2'h1,
		MODE_STX = 2'h2,
		MODE_SRX = 2'h3
	} twm_mode_t;
endpackage
`default_nettype wire

/* sim/twm_ctrl_checker.sv */
// Port-level assertions for the two-wire master transmitter.
`timescale 1ns/1ps
`default_nettype none
module twm_ctrl_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sda_in,
	input wire logic sda_o,
	input wire logic sda_oe_n
);
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_high_a: assert property (psel |-> pready)
		else $error("pready low during a transfer");
	slverr_map_a: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr disagrees with the address map");
	unmapped_zero_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	status_fmt_a: assert property (acc && !pwrite && paddr == twm_pkg::OFF_STATUS |-> !prdata[2])
		else $error("status reserved bit set");
	start_free_bus_a: assert property ($fell(sda_oe_n) && scl_oe_n |-> $past(scl_in) && $past(sda_in))
		else $error("start on a busy bus");
	disable_release_a: assert property (acc && pwrite && paddr == twm_pkg::OFF_CTRL
		&& !pwdata[twm_pkg::B_EN] |-> ##[1:2] (scl_oe_n && sda_oe_n))
		else $error("lines held after disable");
	open_drain_a: assert property (scl_o == 1'h0 && sda_o == 1'h0)
		else $error("line driven high");
	cover property ($fell(sda_oe_n) && scl_oe_n);
	cover property (acc && pslverr);
	cover property (acc && !pwrite && paddr == twm_pkg::OFF_STATUS && prdata[7:0] == 8'h38);
endmodule
bind twm_ctrl twm_ctrl_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
	.sda_in(sda_in), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
`default_nettype wire

/* sim/twm_ctrl_test.sv */
// Bench where APB software drives the master through each transfer kind against a slave model.
`timescale 1ns/1ps
`default_nettype none
module twm_ctrl_test;
	localparam logic [7:0] MR_ACK = 8'hD0;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl_o, sda_o, err;
	logic m_scl_n, m_sda_n, s_scl_n, s_sda_n, ack_on, stretch, rogue_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] last_byte, d;
	int n_bytes, n_stops, n_mismatch, n_tests, seed, k;
	wire logic scl = m_scl_n & s_scl_n;
	wire logic sda = m_sda_n & s_sda_n & rogue_n;
	twm_ctrl #(.MR_ADDR_ACK(MR_ACK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_o(scl_o), .scl_oe_n(m_scl_n),
		.sda_in(sda), .sda_o(sda_o), .sda_oe_n(m_sda_n));
	twm_slave_model slv_u (.scl(scl), .sda(sda), .ack_on(ack_on), .stretch(stretch),
		.sda_oe_n(s_sda_n), .scl_oe_n(s_scl_n), .last_byte(last_byte), .n_bytes(n_bytes),
		.n_stops(n_stops));
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task automatic wrap_up();
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_up();
		chk(32'h0000_0000, 32'h0000_0001);
		wrap_up();
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
			give_up();
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	// Polls the control register; a bus that never answers ends the run.
	task automatic wait_bit(input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			apb(1'h0, twm_pkg::OFF_CTRL, 32'h0000_0000);
			n++;
		end
		while (q[b] !== v && n < 3000);
		if (q[b] !== v)
			give_up();
	endtask
	function automatic logic [7:0] code_for(input logic is_addr, input logic acked);
		if (is_addr)
			return acked ? twm_pkg::CODE_AW_ACK : twm_pkg::CODE_AW_NACK;
		return acked ? twm_pkg::CODE_D_ACK : twm_pkg::CODE_D_NACK;
	endfunction
	task automatic send_byte(input logic [7:0] b, input logic acked, input logic [7:0] code);
		ack_on <= acked;
		apb(1'h1, twm_pkg::OFF_DATA, {24'h00_0000, b});
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_0084);
		wait_bit(twm_pkg::B_FLAG, 1'h1);
		chk(q[twm_pkg::B_WCOL], 1'h0);
		apb(1'h0, twm_pkg::OFF_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_00F8, {24'h00_0000, code});
		chk(last_byte, b);
	endtask
	initial
	begin
		seed = 17252;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		ack_on = 1'h1;
		stretch = 1'h0;
		rogue_n = 1'h1;
		n_mismatch = 0;
		n_tests = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		rd_chk(twm_pkg::OFF_CTRL, 32'h0000_0000);
		rd_chk(twm_pkg::OFF_DATA, {24'h00_0000, twm_pkg::DATA_RST});
		rd_chk(twm_pkg::OFF_STATUS, {24'h00_0000, twm_pkg::CODE_RST});
		rd_chk(twm_pkg::OFF_RATE, {24'h00_0000, twm_pkg::RATE_RST});
		rd_chk(twm_pkg::OFF_INFO, {30'h0000_0000, twm_pkg::MODE_SRX});
		rd_chk(12'h014, 32'h0000_0000);
		chk(err, 1'h1);
		apb(1'h1, twm_pkg::OFF_RATE, 32'h0000_0003);
		apb(1'h1, twm_pkg::OFF_DATA, 32'h0000_005A);
		rd_chk(twm_pkg::OFF_DATA, {24'h00_0000, twm_pkg::DATA_RST});
		apb(1'h0, twm_pkg::OFF_CTRL, 32'h0000_0000);
		chk(q[twm_pkg::B_WCOL], 1'h1);
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_00A4);
		wait_bit(twm_pkg::B_FLAG, 1'h1);
		rd_chk(twm_pkg::OFF_STATUS, {24'h00_0000, twm_pkg::CODE_START});
		k = n_bytes;
		repeat (80) @(posedge pclk);
		chk(scl, 1'h0);
		chk(n_bytes, k);
		send_byte(8'hA0, 1'h1, code_for(1'h1, 1'h1));
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($random(seed));
			stretch <= (i == 1);
			send_byte(d, i < 3, code_for(1'h0, i < 3));
		end
		stretch <= 1'h0;
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_00A4);
		wait_bit(twm_pkg::B_FLAG, 1'h1);
		rd_chk(twm_pkg::OFF_STATUS, {24'h00_0000, twm_pkg::CODE_RSTART});
		send_byte(8'hB0, 1'h0, code_for(1'h1, 1'h0));
		k = n_stops;
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_00B4);
		wait_bit(twm_pkg::B_FLAG, 1'h1);
		rd_chk(twm_pkg::OFF_STATUS, {24'h00_0000, twm_pkg::CODE_START});
		chk(n_stops, k + 1);
		send_byte(8'hA1, 1'h1, MR_ACK);
		apb(1'h0, twm_pkg::OFF_INFO, 32'h0000_0000);
		chk(q[1:0], twm_pkg::MODE_MRX);
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_0094);
		wait_bit(twm_pkg::B_STO, 1'h0);
		chk(q[twm_pkg::B_FLAG], 1'h0);
		chk(n_stops, k + 2);
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_00A4);
		wait_bit(twm_pkg::B_FLAG, 1'h1);
		rogue_n <= 1'h0;
		apb(1'h1, twm_pkg::OFF_DATA, 32'h0000_00FF);
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_0084);
		wait_bit(twm_pkg::B_FLAG, 1'h1);
		rd_chk(twm_pkg::OFF_STATUS, {24'h00_0000, twm_pkg::CODE_LOST});
		apb(1'h0, twm_pkg::OFF_INFO, 32'h0000_0000);
		chk(q[1:0], twm_pkg::MODE_SRX);
		rogue_n <= 1'h1;
		apb(1'h1, twm_pkg::OFF_CTRL, 32'h0000_0000);
		repeat (4) @(posedge pclk);
		chk({scl, sda}, 2'h3);
		wrap_up();
	end
endmodule
`default_nettype wire

/* sim/twm_slave_model.sv */
// Slave receiver on the two-wire bus that acknowledges on command and can stretch the clock.
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_on,
	input wire logic stretch,
	output var logic sda_oe_n,
	output var logic scl_oe_n,
	output var logic [7:0] last_byte,
	output var int n_bytes,
	output var int n_stops
);
	logic [7:0] sh;
	int cnt;
	initial
	begin
		sda_oe_n = 1'h1;
		scl_oe_n = 1'h1;
		last_byte = 8'h00;
		n_bytes = 0;
		n_stops = 0;
		cnt = 0;
	end
	always @(negedge sda)
		if (scl)
			cnt = 0;
	always @(posedge sda)
		if (scl)
		begin
			cnt = 0;
			n_stops++;
		end
	always @(posedge scl)
		if (cnt < 8)
		begin
			sh = {sh[6:0], sda};
			cnt++;
		end
	always @(negedge scl)
	begin
		if (cnt == 8)
		begin
			last_byte = sh;
			n_bytes++;
			sda_oe_n = !ack_on;
			cnt = 9;
		end
		else if (cnt == 9)
		begin
			sda_oe_n = 1'h1;
			cnt = 0;
		end
		// The acknowledge is set first, so it is stable before the stretched clock rises.
		if (stretch)
		begin
			scl_oe_n = 1'h0;
			#300 scl_oe_n = 1'h1;
		end
	end
endmodule
`default_nettype wire
